// file: logic/otpsq_host.sv
// Notes on behaviour
// - Host never issues sector erase in secure mode; device would erase.
// - Protect: write 60h setup, then 60h with region address and select 010.
// - Verify reads bit 0 at region address, select 010; reapply pulse if 0.
// - Host polls at the address being erased or programmed.
// - Bit 7 may turn valid first; host reads once more for full data.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
module otpsq_host #(
    parameter bit TOP_BOOT = 1'b1,
    parameter logic [7:0] ENTER_CODE = otpsq_pkg::DEF_ENTER_CODE,
    parameter logic [7:0] EXIT_CODE = otpsq_pkg::DEF_EXIT_CODE,
    parameter logic [7:0] EXIT_CODE2 = otpsq_pkg::DEF_EXIT_CODE2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [20:0] flash_addr,
    input wire logic [15:0] flash_dq_i,
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n
);
    import otpsq_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_LOAD, S_ADDR, S_STRB, S_RECOV, S_DECIDE, S_RST} otpsq_state_e;
    typedef enum logic [1:0] {PH_SEQ, PH_POLL, PH_FINAL, PH_VERIFY} otpsq_phase_e;

    otpsq_state_e state_q;
    otpsq_phase_e phase_q;
    logic [2:0] op_q, idx_q;
    logic [3:0] cnt_q;
    logic [4:0] tries_q;
    logic [20:0] addr_q;
    logic [15:0] wdata_q, rd_q;
    logic done_q, fail_q, secure_q, timeout_q, refused_q, dq5_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, wmask, status;
    logic wr_fire, ar_fire, start, target;
    logic [20:0] prot_addr;
    otpsq_step_s cur;

    // ========================================
    // Step table: every write sequence except protect opens with the two unlock cycles.
    function automatic otpsq_step_s seq_step(logic [2:0] op, logic [2:0] idx, logic [20:0] a,
                                             logic [15:0] d, logic [20:0] pa);
        otpsq_step_s s;
        s = '{last: 1'b1, rd: 1'b0, addr: a, data: 16'h0000};
        if (op == OP_READ) begin
            s.rd = 1'b1;
        end else if (op == OP_PROTECT) begin
            s.addr = pa;
            s.data = {8'h00, CODE_PROTECT};
            s.last = (idx == 3'h1);
        end else if (idx == 3'h0 || (op == OP_ERASE && idx == 3'h3)) begin
            s = '{last: 1'b0, rd: 1'b0, addr: UNLOCK_ADDR1, data: {8'h00, CODE_UNLOCK1}};
        end else if (idx == 3'h1 || (op == OP_ERASE && idx == 3'h4)) begin
            s = '{last: 1'b0, rd: 1'b0, addr: UNLOCK_ADDR2, data: {8'h00, CODE_UNLOCK2}};
        end else if (idx == 3'h2) begin
            s.addr = UNLOCK_ADDR1;
            s.last = (op == OP_ENTER);
            case (op)
                OP_ENTER: s.data = {8'h00, ENTER_CODE};
                OP_EXIT: s.data = {8'h00, EXIT_CODE};
                OP_PROGRAM: s.data = {8'h00, CODE_PROGRAM};
                default: s.data = {8'h00, CODE_ERASE_SETUP};
            endcase
        end else begin
            case (op)
                OP_EXIT: s.data = {8'h00, EXIT_CODE2};
                OP_PROGRAM: s.data = d;
                default: s.data = {8'h00, CODE_SECTOR_ERASE};
            endcase
        end
        return s;
    endfunction : seq_step

    // Protect always aims at the secure region, so no ordinary group is hit by mistake.
    assign prot_addr = ((TOP_BOOT ? SECURE_TOP_BASE : SECURE_BOT_BASE) & ~PSEL_CLEAR_MASK) | PSEL_SET;

    // Polls reuse the operation's own address; verify reads go to the protect address.
    always_comb begin
        if (phase_q == PH_SEQ) begin
            cur = seq_step(op_q, idx_q, addr_q, wdata_q, prot_addr);
        end else begin
            cur = '{last: 1'b1, rd: 1'b1, addr: (phase_q == PH_VERIFY) ? prot_addr : addr_q, data: 16'h0000};
        end
    end

    // Program polls for the written bit 7, erase for a one.
    assign target = (op_q == OP_PROGRAM) ? wdata_q[POLL_BIT] : 1'b1;

    // ========================================
    // AXI4-Lite slave; address and data are taken together.
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign ar_fire = s_axi_arvalid && !rvalid_q;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign start = wr_fire && s_axi_awaddr == REG_CMD && s_axi_wstrb[0] && state_q == S_IDLE;
    always_comb begin
        status = 32'h0000_0000;
        status[ST_BUSY] = (state_q != S_IDLE);
        status[ST_DONE] = done_q;
        status[ST_FAIL] = fail_q;
        status[ST_SECURE] = secure_q;
        status[ST_TIMEOUT] = timeout_q;
        status[ST_REFUSED] = refused_q;
    end

    // Write channel; unmapped offsets answer SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            addr_q <= 21'h00_0000;
            wdata_q <= 16'h0000;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= (s_axi_awaddr inside {REG_CMD, REG_ADDR, REG_WDATA, REG_STATUS, REG_RDATA})
                           ? RESP_OKAY : RESP_SLVERR;
                if (s_axi_awaddr == REG_ADDR && state_q == S_IDLE) begin
                    addr_q <= 21'((32'(addr_q) & ~wmask) | (s_axi_wdata & wmask));
                end
                if (s_axi_awaddr == REG_WDATA && state_q == S_IDLE) begin
                    wdata_q <= 16'((32'(wdata_q) & ~wmask) | (s_axi_wdata & wmask));
                end
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (s_axi_araddr)
                REG_CMD: rdata_q <= {29'h0000_0000, op_q};
                REG_ADDR: rdata_q <= {11'h000, addr_q};
                REG_WDATA: rdata_q <= {16'h0000, wdata_q};
                REG_STATUS: rdata_q <= status;
                REG_RDATA: rdata_q <= {16'h0000, rd_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ========================================
    // Sequencer: bus cycles, polling, verify and status flags.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            phase_q <= PH_SEQ;
            op_q <= OP_READ;
            idx_q <= 3'h0;
            cnt_q <= 4'h0;
            tries_q <= 5'h00;
            rd_q <= 16'h0000;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            secure_q <= 1'b0;
            timeout_q <= 1'b0;
            refused_q <= 1'b0;
            dq5_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: if (start) begin
                    op_q <= s_axi_wdata[2:0];
                    idx_q <= 3'h0;
                    tries_q <= 5'h00;
                    phase_q <= PH_SEQ;
                    done_q <= 1'b0;
                    fail_q <= 1'b0;
                    timeout_q <= 1'b0;
                    refused_q <= 1'b0;
                    dq5_q <= 1'b0;
                    // Erase in secure mode would wipe the overlaid data, so it is refused.
                    if ((s_axi_wdata[2:0] == OP_ERASE && secure_q) ||
                        (s_axi_wdata[2:0] == OP_PROTECT && !secure_q) || s_axi_wdata[2:0] > OP_HWRESET) begin
                        refused_q <= 1'b1;
                        fail_q <= 1'b1;
                        done_q <= 1'b1;
                    end else if (s_axi_wdata[2:0] == OP_HWRESET) begin
                        cnt_q <= RP_CYC;
                        state_q <= S_RST;
                    end else begin
                        state_q <= S_LOAD;
                    end
                end
                S_LOAD: state_q <= S_ADDR;
                S_ADDR: begin
                    cnt_q <= cur.rd ? ACC_CYC : WP_CYC;
                    state_q <= S_STRB;
                end
                S_STRB: if (cnt_q != CNT_LAST) begin
                    cnt_q <= cnt_q - CNT_LAST;
                end else begin
                    if (cur.rd) begin
                        rd_q <= flash_dq_i;
                    end
                    state_q <= S_RECOV;
                end
                S_RECOV: state_q <= S_DECIDE;
                S_DECIDE: begin
                    state_q <= S_LOAD;
                    case (phase_q)
                        PH_SEQ: if (!cur.last) begin
                            idx_q <= idx_q + 3'h1;
                        end else if (op_q == OP_PROGRAM || op_q == OP_ERASE) begin
                            phase_q <= PH_POLL;
                        end else if (op_q == OP_PROTECT) begin
                            phase_q <= PH_VERIFY;
                        end else begin
                            secure_q <= (op_q == OP_ENTER) ? 1'b1 : (op_q == OP_EXIT) ? 1'b0 : secure_q;
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        PH_POLL: if (rd_q[POLL_BIT] == target) begin
                            phase_q <= PH_FINAL;
                        end else if (dq5_q) begin
                            fail_q <= 1'b1;
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (rd_q[TIMEOUT_BIT]) begin
                            // Bit 7 may settle just as the limit trips, so poll once more.
                            dq5_q <= 1'b1;
                            timeout_q <= 1'b1;
                        end
                        PH_FINAL: begin
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        default: if (rd_q[VERIFY_BIT]) begin
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else if (tries_q == MAX_PROTECT_TRIES) begin
                            fail_q <= 1'b1;
                            done_q <= 1'b1;
                            state_q <= S_IDLE;
                        end else begin
                            tries_q <= tries_q + 5'h01;
                            phase_q <= PH_SEQ;
                            idx_q <= 3'h1;
                        end
                    endcase
                end
                S_RST: if (cnt_q != CNT_LAST) begin
                    cnt_q <= cnt_q - CNT_LAST;
                end else begin
                    secure_q <= 1'b0;
                    done_q <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ========================================
    // Flash pins, all from flops; strobes never overlap.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_addr <= 21'h00_0000;
            flash_dq_o <= 16'h0000;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_reset_n <= 1'b1;
        end else begin
            flash_reset_n <= !(state_q == S_IDLE && start && s_axi_wdata[2:0] == OP_HWRESET)
                             && !(state_q == S_RST && cnt_q != CNT_LAST);
            if (state_q == S_LOAD) begin
                flash_addr <= cur.addr;
                flash_dq_o <= cur.data;
                flash_dq_oe <= !cur.rd;
                flash_ce_n <= 1'b0;
            end else if (state_q == S_ADDR) begin
                flash_oe_n <= !cur.rd;
                flash_we_n <= cur.rd;
            end else if (state_q == S_STRB && cnt_q == CNT_LAST) begin
                flash_oe_n <= 1'b1;
                flash_we_n <= 1'b1;
            end else if (state_q == S_RECOV) begin
                flash_ce_n <= 1'b1;
                flash_dq_oe <= 1'b0;
            end
        end
    end

    // ========================================
    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_no_erase_secure; (state_q != S_IDLE && op_q == OP_ERASE) |-> !secure_q; endproperty
    a_no_erase_secure: assert property (p_no_erase_secure) else $error("erase under way in secure mode");
    property p_protect_write;
        (!flash_we_n && op_q == OP_PROTECT) |->
            flash_dq_o[7:0] == CODE_PROTECT && (flash_addr & PSEL_CLEAR_MASK) == PSEL_SET;
    endproperty
    a_protect_write: assert property (p_protect_write) else $error("bad protect write");
    property p_verify_retry;
        (state_q == S_DECIDE && phase_q == PH_VERIFY && !rd_q[VERIFY_BIT] && tries_q != MAX_PROTECT_TRIES)
            |=> phase_q == PH_SEQ && idx_q == 3'h1 ##2 !flash_we_n;
    endproperty
    a_verify_retry: assert property (p_verify_retry) else $error("protect pulse not reapplied");
    property p_poll_addr; (!flash_oe_n && phase_q == PH_POLL) |-> flash_addr == addr_q; endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("poll read at wrong address");
    property p_final_read;
        (state_q == S_DECIDE && phase_q == PH_POLL && rd_q[POLL_BIT] == target)
            |=> phase_q == PH_FINAL ##2 !flash_oe_n;
    endproperty
    a_final_read: assert property (p_final_read) else $error("no confirming read");
    property p_reset_exit; (state_q == S_RST && cnt_q == CNT_LAST) |=> !secure_q && flash_reset_n; endproperty
    a_reset_exit: assert property (p_reset_exit) else $error("secure mode kept after reset");
    property p_unlock_first;
        (!flash_we_n && phase_q == PH_SEQ && idx_q == 3'h0 && op_q != OP_PROTECT)
            |-> flash_addr == UNLOCK_ADDR1 && flash_dq_o[7:0] == CODE_UNLOCK1;
    endproperty
    a_unlock_first: assert property (p_unlock_first) else $error("sequence lacks unlock");
    property p_poll_after_prog;
        (state_q == S_DECIDE && phase_q == PH_SEQ && cur.last && op_q == OP_PROGRAM) |=> phase_q == PH_POLL;
    endproperty
    a_poll_after_prog: assert property (p_poll_after_prog) else $error("no poll after program");
    property p_no_contention; flash_dq_oe |-> flash_oe_n; endproperty
    a_no_contention: assert property (p_no_contention) else $error("data bus contention");

endmodule : otpsq_host

// file: inc/otpsq_pkg.sv
package otpsq_pkg;

    // ========================================
    // Timing, all at a 20 MHz system clock.
    localparam int CLK_MHZ = 20;
    localparam int T_ACC_NS = 100;
    localparam int T_WP_NS = 50;
    localparam int T_RP_NS = 500;

    // Least times round up to whole cycles, never below one.
    function automatic int cyc_min(int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    localparam logic [3:0] ACC_CYC = 4'(cyc_min(T_ACC_NS));
    localparam logic [3:0] WP_CYC = 4'(cyc_min(T_WP_NS));
    localparam logic [3:0] RP_CYC = 4'(cyc_min(T_RP_NS));
    localparam logic [3:0] CNT_LAST = 4'h1;

    // ========================================
    // Memory map of the flash in word mode, and its byte-mode twin.
    localparam logic [20:0] UNLOCK_ADDR1 = 21'h00_0555;
    localparam logic [20:0] UNLOCK_ADDR2 = 21'h00_02AA;
    localparam logic [20:0] SECURE_TOP_BASE = 21'h1F_FFE0;
    localparam logic [20:0] SECURE_BOT_BASE = 21'h00_0000;
    localparam logic [20:0] SECURE_BOT_END = 21'h00_0040;
    localparam logic [21:0] SECURE_TOP_BYTE_BASE = 22'h3F_FFC0;
    localparam logic [21:0] SECURE_BOT_BYTE_END = 22'h00_0080;
    // Protect-select lines (upper, middle, lower) = (0,1,0).
    localparam logic [20:0] PSEL_CLEAR_MASK = 21'h00_0043;
    localparam logic [20:0] PSEL_SET = 21'h00_0002;

    // ========================================
    // Command codes.
    localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CODE_PROTECT = 8'h60;
    localparam logic [7:0] DEF_ENTER_CODE = 8'h88;
    localparam logic [7:0] DEF_EXIT_CODE = 8'h90;
    localparam logic [7:0] DEF_EXIT_CODE2 = 8'h00;

    // Status bit positions on the data lines.
    localparam int POLL_BIT = 7;
    localparam int TIMEOUT_BIT = 5;
    localparam int VERIFY_BIT = 0;
    localparam logic [4:0] MAX_PROTECT_TRIES = 5'h19;

    // ========================================
    // Operations written to the command register.
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_ENTER = 3'h1;
    localparam logic [2:0] OP_EXIT = 3'h2;
    localparam logic [2:0] OP_PROGRAM = 3'h3;
    localparam logic [2:0] OP_ERASE = 3'h4;
    localparam logic [2:0] OP_PROTECT = 3'h5;
    localparam logic [2:0] OP_HWRESET = 3'h6;

    // ========================================
    // Controller registers and status fields.
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_WDATA = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [11:0] REG_RDATA = 12'h010;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_SECURE = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_REFUSED = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic last;
        logic rd;
        logic [20:0] addr;
        logic [15:0] data;
    } otpsq_step_s;

endpackage : otpsq_pkg

// file: bench/otpsq_flash_model.sv
module otpsq_flash_model
    import otpsq_pkg::*;
(
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic tmo,
    input wire logic [3:0] busy_n,
    input wire logic [1:0] pfail,
    output logic [15:0] flash_dq_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Flash behaviour: sparse array, secure overlay on the boot sector, status polling.
    logic [15:0] mem[int], sec[int], last = 0, v;
    logic on = 0, prot = 0, pn = 0, vfy = 0, ers = 0, tog = 0, p60 = 0;
    int busy = 0, tries = 0;
    wire logic hit = on && flash_addr >= 21'h1F_F000;
    // Writes latch on the rising write strobe; a program overwrites rather than ANDs bits.
    always @(posedge flash_we_n or negedge flash_reset_n) begin
        if (!flash_reset_n) begin
            on = 0;
            busy = 0;
        end else if (flash_ce_n || !flash_dq_oe) begin
            // With the chip deselected or the data lines undriven, a strobe writes nothing.
        end else if (pn) begin
            pn = 0;
            last = flash_dq_o;
            ers = 0;
            busy = busy_n + 1;
            if (!hit) mem[flash_addr] = last;
            else if (!prot) sec[flash_addr] = last;
        end else begin
            if (p60 && flash_dq_o[7:0] == CODE_PROTECT) begin
                tries++;
                vfy = 1;
                prot = prot | (hit && tries > pfail);
            end
            p60 = flash_dq_o[7:0] == CODE_PROTECT;
            case (flash_dq_o[7:0])
                CODE_PROGRAM: pn = 1;
                DEF_ENTER_CODE: on = 1;
                DEF_EXIT_CODE: on = 0;
                CODE_SECTOR_ERASE: begin
                    ers = 1;
                    busy = busy_n + 1;
                    if (hit) sec.delete(flash_addr);
                    else mem.delete(flash_addr);
                end
                default: ;
            endcase
        end
    end
    // Status stands in for data while busy and on the read after a protect pulse; a stuck timeout never finishes.
    always @(negedge flash_oe_n) begin
        if (flash_ce_n) v = 16'hxxxx; // A deselected chip leaves the lines floating.
        else if (vfy) v = {15'h0000, prot};
        else if (busy > 0) begin
            tog = ~tog;
            busy = busy - int'(!tmo);
            v = {8'h00, !ers && !last[7], tog, tmo, 1'b0, ers, !ers || tog, 2'b00};
        end else if (hit) v = sec.exists(flash_addr) ? sec[flash_addr] : 16'hFFFF;
        else v = mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
        vfy = 0;
        flash_dq_i <= #20 v;
    end
    // Released lines show the inverse so a stale value never looks fresh.
    always @(posedge flash_oe_n) flash_dq_i <= #10 ~flash_dq_i;
endmodule : otpsq_flash_model

// file: bench/otpsq_host_test.sv
module otpsq_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    import otpsq_pkg::*;
    // ========================================
    // Signals, instances and clock.
    logic aclk = 0, aresetn = 0, tmo = 0, ron = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb = 4'hF, busy_n = 0;
    logic [1:0] pfail = 0, s_axi_bresp, s_axi_rresp, resp;
    logic [20:0] flash_addr, a;
    logic [15:0] flash_dq_i, flash_dq_o, lf = 16'h6166, d0;
    int errors = 0, num_checks = 0, n;
    otpsq_host otpsq_host_i (.*);
    otpsq_flash_model otpsq_flash_model_i (.*);
    always #25 aclk = ~aclk;
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    // Expected status words follow the mode flag that the bench tracks itself.
    function automatic logic [5:0] ok();
        return {2'b00, ron, 3'b010};
    endfunction : ok
    function automatic logic [5:0] bad();
        return {2'b10, ron, 3'b110};
    endfunction : bad
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    // ========================================
    // Bus tasks; each is entered just after a rising edge and leaves just after one.
    task automatic axw(input logic [11:0] ad, input logic [31:0] dt);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask : axw
    task automatic axr(input logic [11:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        r = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : axr
    // One operation, polled with a bounded count so a stuck busy flag shows as a mismatch.
    task automatic run(input logic [2:0] op, input logic [20:0] ad, input logic [15:0] dt, input logic [5:0] st);
        axw(REG_ADDR, 32'(ad));
        axw(REG_WDATA, 32'(dt));
        axw(REG_CMD, 32'(op));
        n = 0;
        do begin
            axr(REG_STATUS);
            n++;
        end while (r[ST_BUSY] !== 1'b0 && n < 999);
        chk(r, 32'(st));
    endtask : run
    task automatic rd(input logic [20:0] ad, input logic [15:0] e);
        run(OP_READ, ad, 16'h0000, ok());
        axr(REG_RDATA);
        chk(r, 32'(e));
    endtask : rd
    // The whole run needs some 1,500 cycles; the watchdog allows 60,000, forty times that.
    initial begin
        #3_000_000;
        errors++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axr(12'h020);
        chk({r[31:2], resp}, 32'(RESP_SLVERR));
        for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            a = {5'h00, lf};
            d0 = nxt(lf);
            busy_n <= 4'(i * 3);
            run(OP_PROGRAM, a, d0, ok());
            rd(a, d0);
            run(OP_ERASE, a, 16'h0000, ok());
            rd(a, 16'hFFFF);
        end
        a = 21'h1F_FFE4;
        run(OP_PROGRAM, a, d0, ok());
        ron = 1;
        run(OP_ENTER, a, 16'h0000, ok());
        rd(a, 16'hFFFF);
        run(OP_PROGRAM, a, ~d0, ok());
        rd(a, ~d0);
        run(OP_PROGRAM, 21'h00_0010, d0, ok());
        rd(21'h00_0010, d0);
        run(OP_ERASE, a, 16'h0000, bad());
        pfail <= 2;
        run(OP_PROTECT, a, 16'h0000, ok());
        // A refused program keeps the old word, so poll for a value whose bit 7 that word shares.
        run(OP_PROGRAM, a, ~d0 ^ 16'h0001, ok());
        rd(a, ~d0);
        ron = 0;
        run(OP_EXIT, a, 16'h0000, ok());
        rd(a, d0);
        run(OP_PROTECT, a, 16'h0000, bad());
        run(3'h7, a, 16'h0000, bad());
        ron = 1;
        run(OP_ENTER, a, 16'h0000, ok());
        tmo <= 1;
        run(OP_PROGRAM, 21'h00_0020, d0, {2'b01, ron, 3'b110});
        tmo <= 0;
        ron = 0;
        run(OP_HWRESET, a, 16'h0000, ok());
        rd(a, d0);
        end_of_test;
    end
endmodule : otpsq_host_test
